// ### rtl/spcs_pkg.sv
// Purpose: constants and types for the serial potentiometer command slave
// Assumes: core_clk at 250 MHz; bus pins synchronised before use
// Notes: stored positions are held in flip-flops in this model
// What this block does
// R1: Transmitter releases data after eight bits; receiver pulls low on ninth.
// R2: Acknowledge matching address, instruction byte and each data byte.
// R3: Stop after a stored-register write command starts the internal write.
// R4: During internal write ignore inputs and never acknowledge an address.
// R5: Master polls with start plus address until acknowledged.
// R6: Upper four address bits must equal the device type code.
// R7: Three address bits must match the address pins for execution.
// R8: Address byte LSB selects direction: 1 read, 0 write.
// R9: Instruction byte: opcode, zero, two select bits, two zeros.
// R10: Read wiper with 1/100; write wiper with 0/101.
// R11: Read stored register with 1/101; write it with 0/110.
// R12: Copy stored to wiper with 1/110; wiper to stored with 0/111.
// R13: Data commands carry two bytes: bits 9..8 first, then 7..0.
// R14: Transfer commands are address and instruction only, then stop.
// R15: Ten-bit wiper decodes to exactly one of 1024 taps.
// R16: Wiper changes only by write, transfer, or power-up load.
// R17: Wiper is volatile and reloaded, never assumed retained.
// R18: Four ten-bit stored registers; changes finish within 10 ms.
// R19: Stored-to-wiper acts after a short settle; reverse is a stored write.
// R20: Write-protect low blocks every stored-register write.
// R21: Sample data on clock rise, change outputs after clock fall.
// R22: Detect start and stop; ignore everything until a start.
// R23: Direct wiper write takes effect after final data acknowledge.
package spcs_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_MHZ;
    localparam int unsigned NV_WRITE_TIME_US = 5000;
    localparam int unsigned NV_WRITE_CYC = NV_WRITE_TIME_US * CLK_MHZ;
    localparam int unsigned NV_CNT_W = 21;
    localparam int unsigned WIPER_SETTLE_NS = 20;
    localparam int unsigned WIPER_SETTLE_CYC =
        (WIPER_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef logic [NV_CNT_W-1:0] spcs_nvcnt_t;
    localparam logic [3:0] SETTLE_LOAD = 4'(WIPER_SETTLE_CYC);
    localparam logic [3:0] BIT_COUNT_FULL = 4'h8;
    // Device type code, value arbitrary
    localparam logic [3:0] DEV_TYPE_DEFAULT = 4'hA;
    localparam logic [9:0] STORED_RESET = 10'h000;
    localparam logic [9:0] WIPER_RESET = 10'h000;
    localparam int unsigned ADDR_TYPE_LSB = 4;
    localparam int unsigned ADDR_PINS_LSB = 1;
    localparam int unsigned ADDR_RW_BIT = 0;
    localparam int unsigned INSTR_OP_LSB = 5;
    localparam int unsigned INSTR_ZERO_BIT = 4;
    localparam int unsigned INSTR_SEL_LSB = 2;
    localparam logic [2:0] OP_RD_WIPER = 3'h4;
    localparam logic [2:0] OP_WR_WIPER = 3'h5;
    localparam logic [2:0] OP_RD_STORED = 3'h5;
    localparam logic [2:0] OP_WR_STORED = 3'h6;
    localparam logic [2:0] OP_COPY_TO_WIPER = 3'h6;
    localparam logic [2:0] OP_COPY_TO_STORED = 3'h7;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ACK_ADDR = 4'h2,
        ST_INSTR = 4'h3,
        ST_ACK_INSTR = 4'h4,
        ST_WDATA = 4'h5,
        ST_ACK_DATA = 4'h6,
        ST_RDATA = 4'h7,
        ST_RACK = 4'h8
    } spcs_st_e;
    typedef struct packed {
        spcs_st_e st;
        logic scl_q;
        logic sda_q;
        logic [7:0] shreg;
        logic [3:0] bitcnt;
        logic drv;
        logic rw;
        logic [2:0] op;
        logic [1:0] sel;
        logic byte1;
        logic [1:0] hi;
        logic [7:0] tx;
        logic mack;
        logic [9:0] wiper;
        logic [3:0][9:0] stored;
        logic nv_busy;
        spcs_nvcnt_t nv_cnt;
        logic [1:0] nv_sel;
        logic [9:0] nv_val;
        logic nv_pend;
        logic [3:0] settle_cnt;
        logic settle_pend;
        logic [9:0] settle_val;
        logic init_done;
    } spcs_state_s;
    localparam spcs_state_s STATE_RESET = '{
        st: ST_IDLE, scl_q: 1'b1, sda_q: 1'b1, wiper: WIPER_RESET,
        stored: {4{STORED_RESET}}, default: '0};
endpackage

// ### rtl/spcs_sync.sv
// Purpose: two-stage synchroniser for bus and strap pins
// Assumes: inputs are asynchronous to core_clk
// Notes: only the second stage is visible outside
`timescale 1ns/1ps
module spcs_sync #(
    parameter int unsigned W = 6
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } spcs_sync_s;
    spcs_sync_s s_r;
    spcs_sync_s s_nxt;

    always_comb begin
        s_nxt.meta = d;
        s_nxt.sync = s_r.meta;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.sync;
endmodule

// ### rtl/spcs_top.sv
// Purpose: two-wire slave and command logic of a serial potentiometer
// Assumes: master drives the serial clock; pins synchronised here
// Notes: tap decode follows the wiper register directly
`timescale 1ns/1ps
module spcs_top #(
    parameter int unsigned NV_WRITE_CYCLES = spcs_pkg::NV_WRITE_CYC,
    parameter logic [3:0] DEV_TYPE = spcs_pkg::DEV_TYPE_DEFAULT
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [2:0] slave_addr_pins,
    input wire logic write_protect_n,
    output logic [9:0] wiper_position,
    output logic [1023:0] tap_sel,
    output logic nv_busy
);
    localparam spcs_pkg::spcs_nvcnt_t NV_LOAD =
        spcs_pkg::spcs_nvcnt_t'(NV_WRITE_CYCLES);

    spcs_pkg::spcs_state_s s_r;
    spcs_pkg::spcs_state_s s_nxt;
    logic [5:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic wp_s;
    logic [2:0] addr_s;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic rx_state;
    logic rx_done;
    logic addr_match;
    logic instr_ok;
    logic [2:0] in_op;
    logic wr_fire;
    logic settle_fire;
    logic wiper_load;

    function automatic logic [9:0] read_val(
        input logic [2:0] op,
        input logic [1:0] sel,
        input logic [9:0] wiper,
        input logic [3:0][9:0] stored
    );
        if (op == spcs_pkg::OP_RD_WIPER) begin
            read_val = wiper;
        end else begin
            read_val = stored[sel];
        end
    endfunction

    spcs_sync #(
        .W(6)
    ) u_sync (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .d({scl_i, sda_i, write_protect_n, slave_addr_pins}),
        .q(pins_s)
    );

    assign scl_s = pins_s[5];
    assign sda_s = pins_s[4];
    assign wp_s = pins_s[3];
    assign addr_s = pins_s[2:0];

    // Edge and condition detection
    assign scl_rise = scl_s & ~s_r.scl_q;
    assign scl_fall = ~scl_s & s_r.scl_q;
    assign start_ev = scl_s & s_r.scl_q & s_r.sda_q & ~sda_s; // [R22]
    assign stop_ev = scl_s & s_r.scl_q & ~s_r.sda_q & sda_s; // [R22]

    assign rx_state = (s_r.st == spcs_pkg::ST_ADDR) ||
        (s_r.st == spcs_pkg::ST_INSTR) || (s_r.st == spcs_pkg::ST_WDATA);
    assign rx_done = scl_fall && (s_r.bitcnt == spcs_pkg::BIT_COUNT_FULL);

    // Address compare
    assign addr_match =
        (s_r.shreg[spcs_pkg::ADDR_TYPE_LSB +: 4] == DEV_TYPE) && // [R6]
        (s_r.shreg[spcs_pkg::ADDR_PINS_LSB +: 3] == addr_s); // [R7]

    // Instruction decode
    assign in_op = s_r.shreg[spcs_pkg::INSTR_OP_LSB +: 3];
    always_comb begin
        instr_ok = ~s_r.shreg[spcs_pkg::INSTR_ZERO_BIT] &&
            (s_r.shreg[1:0] == 2'h0); // [R9]
        if (s_r.rw) begin
            instr_ok = instr_ok && ((in_op == spcs_pkg::OP_RD_WIPER) ||
                (in_op == spcs_pkg::OP_RD_STORED) ||
                (in_op == spcs_pkg::OP_COPY_TO_WIPER)); // [R10] [R11] [R12]
        end else begin
            instr_ok = instr_ok && ((in_op == spcs_pkg::OP_WR_WIPER) ||
                (in_op == spcs_pkg::OP_WR_STORED) ||
                (in_op == spcs_pkg::OP_COPY_TO_STORED)); // [R10] [R11] [R12]
        end
    end

    assign wr_fire = (s_r.st == spcs_pkg::ST_ACK_DATA) && scl_fall &&
        !start_ev && !stop_ev && s_r.byte1 &&
        (s_r.op == spcs_pkg::OP_WR_WIPER);
    assign settle_fire = s_r.settle_pend && (s_r.settle_cnt == 4'h1);
    assign wiper_load = !s_r.init_done || settle_fire || wr_fire;

    always_comb begin
        logic [9:0] rd;
        logic [7:0] tx0;
        rd = read_val(s_r.op, s_r.sel, s_r.wiper, s_r.stored);
        tx0 = 8'h00;
        s_nxt = s_r;
        s_nxt.scl_q = scl_s;
        s_nxt.sda_q = sda_s;
        // Power-up load of the wiper from stored register zero
        if (!s_r.init_done) begin
            s_nxt.wiper = s_r.stored[0]; // [R16] [R17]
            s_nxt.init_done = 1'b1;
        end
        // Delayed stored-to-wiper transfer
        if (s_r.settle_pend) begin
            if (settle_fire) begin
                s_nxt.wiper = s_r.settle_val; // [R19]
                s_nxt.settle_pend = 1'b0;
            end else begin
                s_nxt.settle_cnt = s_r.settle_cnt - 4'h1;
            end
        end
        // Internal stored-register write cycle
        if (s_r.nv_busy) begin
            if (s_r.nv_cnt == spcs_pkg::spcs_nvcnt_t'(1)) begin
                s_nxt.stored[s_r.nv_sel] = s_r.nv_val; // [R18]
                s_nxt.nv_busy = 1'b0;
            end else begin
                s_nxt.nv_cnt = s_r.nv_cnt - spcs_pkg::spcs_nvcnt_t'(1);
            end
        end
        if (rx_state && scl_rise) begin
            s_nxt.shreg = {s_r.shreg[6:0], sda_s}; // [R21]
            s_nxt.bitcnt = s_r.bitcnt + 4'h1;
        end
        if (start_ev) begin
            s_nxt.drv = 1'b0;
            s_nxt.bitcnt = 4'h0;
            s_nxt.byte1 = 1'b0;
            s_nxt.nv_pend = 1'b0;
            // Busy device stays deaf so polling gets no acknowledge
            if (s_r.nv_busy) begin
                s_nxt.st = spcs_pkg::ST_IDLE; // [R4] [R5]
            end else begin
                s_nxt.st = spcs_pkg::ST_ADDR; // [R22]
            end
        end else if (stop_ev) begin
            s_nxt.drv = 1'b0;
            s_nxt.st = spcs_pkg::ST_IDLE;
            s_nxt.nv_pend = 1'b0;
            if (s_r.nv_pend && wp_s) begin // [R20]
                s_nxt.nv_busy = 1'b1; // [R3]
                s_nxt.nv_cnt = NV_LOAD;
            end
        end else begin
            case (s_r.st)
                spcs_pkg::ST_ADDR: begin
                    if (rx_done) begin
                        if (addr_match) begin
                            s_nxt.drv = 1'b1; // [R2]
                            s_nxt.rw =
                                s_r.shreg[spcs_pkg::ADDR_RW_BIT]; // [R8]
                            s_nxt.st = spcs_pkg::ST_ACK_ADDR;
                        end else begin
                            s_nxt.st = spcs_pkg::ST_IDLE; // [R7]
                        end
                    end
                end
                spcs_pkg::ST_ACK_ADDR: begin
                    if (scl_fall) begin
                        s_nxt.drv = 1'b0; // [R1]
                        s_nxt.bitcnt = 4'h0;
                        s_nxt.st = spcs_pkg::ST_INSTR;
                    end
                end
                spcs_pkg::ST_INSTR: begin
                    if (rx_done) begin
                        if (instr_ok) begin
                            s_nxt.drv = 1'b1; // [R2]
                            s_nxt.op = in_op; // [R9]
                            s_nxt.sel =
                                s_r.shreg[spcs_pkg::INSTR_SEL_LSB +: 2];
                            s_nxt.st = spcs_pkg::ST_ACK_INSTR;
                        end else begin
                            s_nxt.st = spcs_pkg::ST_IDLE;
                        end
                    end
                end
                spcs_pkg::ST_ACK_INSTR: begin
                    if (scl_fall) begin
                        s_nxt.drv = 1'b0;
                        s_nxt.bitcnt = 4'h0;
                        if (s_r.rw &&
                            s_r.op == spcs_pkg::OP_COPY_TO_WIPER) begin
                            s_nxt.settle_val = s_r.stored[s_r.sel]; // [R12]
                            s_nxt.settle_cnt = spcs_pkg::SETTLE_LOAD; // [R19]
                            s_nxt.settle_pend = 1'b1;
                            s_nxt.st = spcs_pkg::ST_IDLE; // [R14]
                        end else if (!s_r.rw &&
                            s_r.op == spcs_pkg::OP_COPY_TO_STORED) begin
                            s_nxt.nv_pend = 1'b1; // [R12] [R19]
                            s_nxt.nv_sel = s_r.sel;
                            s_nxt.nv_val = s_r.wiper;
                            s_nxt.st = spcs_pkg::ST_IDLE; // [R14]
                        end else if (s_r.rw) begin
                            tx0 = {6'h00, rd[9:8]}; // [R13] [R10] [R11]
                            s_nxt.drv = ~tx0[7];
                            s_nxt.tx = {tx0[6:0], 1'b0};
                            s_nxt.bitcnt = 4'h1;
                            s_nxt.st = spcs_pkg::ST_RDATA;
                        end else begin
                            s_nxt.st = spcs_pkg::ST_WDATA;
                        end
                    end
                end
                spcs_pkg::ST_WDATA: begin
                    if (rx_done) begin
                        s_nxt.drv = 1'b1; // [R2]
                        s_nxt.st = spcs_pkg::ST_ACK_DATA;
                        if (!s_r.byte1) begin
                            s_nxt.hi = s_r.shreg[1:0]; // [R13]
                        end
                    end
                end
                spcs_pkg::ST_ACK_DATA: begin
                    if (scl_fall) begin
                        s_nxt.drv = 1'b0;
                        s_nxt.bitcnt = 4'h0;
                        if (!s_r.byte1) begin
                            s_nxt.byte1 = 1'b1;
                            s_nxt.st = spcs_pkg::ST_WDATA;
                        end else begin
                            if (wr_fire) begin
                                s_nxt.wiper = {s_r.hi, s_r.shreg}; // [R23]
                            end else begin
                                s_nxt.nv_pend = 1'b1; // [R11]
                                s_nxt.nv_sel = s_r.sel;
                                s_nxt.nv_val = {s_r.hi, s_r.shreg};
                            end
                            s_nxt.st = spcs_pkg::ST_IDLE;
                        end
                    end
                end
                spcs_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        if (s_r.bitcnt == spcs_pkg::BIT_COUNT_FULL) begin
                            s_nxt.drv = 1'b0; // [R1]
                            s_nxt.st = spcs_pkg::ST_RACK;
                        end else begin
                            s_nxt.drv = ~s_r.tx[7]; // [R21]
                            s_nxt.tx = {s_r.tx[6:0], 1'b0};
                            s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                        end
                    end
                end
                spcs_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        s_nxt.mack = ~sda_s; // [R1]
                    end else if (scl_fall) begin
                        if (s_r.mack && !s_r.byte1) begin
                            tx0 = rd[7:0]; // [R13]
                            s_nxt.byte1 = 1'b1;
                            s_nxt.drv = ~tx0[7];
                            s_nxt.tx = {tx0[6:0], 1'b0};
                            s_nxt.bitcnt = 4'h1;
                            s_nxt.st = spcs_pkg::ST_RDATA;
                        end else begin
                            s_nxt.st = spcs_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    s_nxt.st = spcs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= spcs_pkg::STATE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = s_r.drv;
    assign wiper_position = s_r.wiper;
    assign nv_busy = s_r.nv_busy;
    assign tap_sel = {{1023{1'b0}}, 1'b1} << s_r.wiper; // [R15]

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_addr_hit;
        (s_r.st == spcs_pkg::ST_ADDR) && rx_done && addr_match &&
            !start_ev && !stop_ev;
    endsequence
    sequence s_copy_wiper;
        (s_r.st == spcs_pkg::ST_ACK_INSTR) && scl_fall && s_r.rw &&
            (s_r.op == spcs_pkg::OP_COPY_TO_WIPER) && !start_ev && !stop_ev;
    endsequence

    a_addr_ack: assert property (s_addr_hit |=> sda_oe) // [R2]
        else $error("matching address not acknowledged");
    a_addr_miss: assert property ( // [R7]
        (s_r.st == spcs_pkg::ST_ADDR) && rx_done && !addr_match &&
        !start_ev && !stop_ev |=> !sda_oe && (s_r.st == spcs_pkg::ST_IDLE))
        else $error("mismatched address acknowledged");
    a_type_gate: assert property ( // [R6]
        (s_r.st == spcs_pkg::ST_ACK_ADDR) |->
        (s_r.shreg[spcs_pkg::ADDR_TYPE_LSB +: 4] == DEV_TYPE))
        else $error("wrong device type accepted");
    a_busy_quiet: assert property (s_r.nv_busy |-> !sda_oe) // [R4]
        else $error("data driven during internal write");
    a_stop_nv: assert property ( // [R3]
        stop_ev && s_r.nv_pend && wp_s |=> s_r.nv_busy &&
        (s_r.nv_cnt == NV_LOAD))
        else $error("internal write not started at stop");
    a_wp_block: assert property ( // [R20]
        $rose(s_r.nv_busy) |-> $past(wp_s))
        else $error("write started while protected");
    a_one_tap: assert property ($onehot(tap_sel)) // [R15]
        else $error("tap decode not one-hot");
    a_wiper_src: assert property ( // [R16]
        $changed(s_r.wiper) |-> $past(wiper_load))
        else $error("wiper changed without a source");
    a_settle_seq: assert property ( // [R19]
        s_copy_wiper |=> s_r.settle_pend [*5] ##1 !s_r.settle_pend)
        else $error("wiper settle timing wrong");
    a_nv_done: assert property ( // [R18]
        s_r.nv_busy && (s_r.nv_cnt == spcs_pkg::spcs_nvcnt_t'(1)) |=>
        !s_r.nv_busy && (s_r.stored[$past(s_r.nv_sel)] == $past(s_r.nv_val)))
        else $error("stored write not completed");
    a_out_on_fall: assert property ( // [R21]
        $changed(sda_oe) |-> $past(scl_fall || start_ev || stop_ev))
        else $error("data output changed off a falling edge");
    a_read_release: assert property ( // [R1]
        (s_r.st == spcs_pkg::ST_RDATA) && scl_fall && !start_ev &&
        !stop_ev && (s_r.bitcnt == spcs_pkg::BIT_COUNT_FULL) |=>
        !sda_oe ##1 (s_r.st == spcs_pkg::ST_RACK))
        else $error("data not released after eight bits");
endmodule

// ### dv/spcs_master.sv
// Purpose: two-wire bus master model driving the potentiometer slave
// Assumes: sda is the resolved wire with a pull-up
// Notes: clock stands high between frames; half period is 8 core cycles
`timescale 1ns/1ps
module spcs_master (
    input wire logic core_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic half();
        repeat (8) @(negedge core_clk);
    endtask
    // Data falls while clock high
    task automatic start();
        sda_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b0;
    endtask
    // Data rises while clock high
    task automatic stop();
        sda_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b0;
        half();
    endtask
    // Data set while clock low, sampled at end of high
    task automatic bitx(input logic b, output logic s);
        sda_low = !b;
        half();
        scl = 1'b1;
        half();
        s = sda;
        scl = 1'b0;
    endtask
    // Eight bits MSB first, then release for the ninth
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(d[i], s);
        bitx(1'b1, s);
        ack = !s;
    endtask
    // Receive eight bits, then pull low on the ninth to ack
    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(!mack, s);
    endtask
endmodule

// ### dv/spcs_top_test.sv
// Purpose: self-checking bench for the potentiometer command slave
// Assumes: short stored-write time via NV_WRITE_CYCLES
// Notes: integer model of wiper and stored positions
`timescale 1ns/1ps
module spcs_top_test;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic scl, sda_low, sda, sda_o, sda_oe, wp_n, busy;
    logic [2:0] pins;
    logic [9:0] wiper;
    logic [1023:0] tap;
    logic [31:0] rnd;
    logic [3:0] dev = spcs_pkg::DEV_TYPE_DEFAULT;
    int n_mismatch = 0;
    int checked = 0;
    int wiper_m;
    int stored_m[4];
    initial forever #2 core_clk = ~core_clk;
    assign sda = ~((sda_oe & ~sda_o) | sda_low);
    spcs_master mst (.core_clk(core_clk), .sda(sda), .scl(scl),
        .sda_low(sda_low));
    spcs_top #(.NV_WRITE_CYCLES(400)) uut (.core_clk(core_clk),
        .arst_n(arst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .slave_addr_pins(pins), .write_protect_n(wp_n),
        .wiper_position(wiper), .tap_sel(tap), .nv_busy(busy));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] ins(input logic [2:0] op, input int s);
        return {op, 1'b0, 2'(s), 2'h0};
    endfunction
    task automatic chk_ack(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask
    task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic cmd(input logic rw, input logic [7:0] i, input logic ea);
        logic a;
        mst.start();
        mst.wbyte({dev, pins, rw}, a);
        chk_ack(a, 1'b1);
        mst.wbyte(i, a);
        chk_ack(a, ea);
    endtask
    task automatic wr(input logic [7:0] i, input int v);
        logic a;
        cmd(1'b0, i, 1'b1);
        rnd = lfsr(rnd);
        mst.wbyte({rnd[5:0], 2'(v >> 8)}, a);
        chk_ack(a, 1'b1);
        mst.wbyte(8'(v), a);
        chk_ack(a, 1'b1);
        mst.stop();
    endtask
    task automatic rd(input logic [7:0] i, input int e);
        logic [7:0] b0, b1;
        cmd(1'b1, i, 1'b1);
        mst.rbyte(1'b1, b0);
        mst.rbyte(1'b0, b1);
        mst.stop();
        chk_val({b0[1:0], b1}, 10'(e));
    endtask
    task automatic poll();
        logic a;
        int n;
        a = 1'b0;
        n = 0;
        chk_ack(busy, 1'b1);
        while (!a && n < 20) begin
            mst.start();
            mst.wbyte({dev, pins, 1'b0}, a);
            mst.stop();
            n++;
        end
        chk_ack(a, 1'b1);
        chk_ack(n > 1, 1'b1);
        chk_ack(busy, 1'b0);
    endtask
    initial begin
        #300000;
        n_mismatch++;
        end_sim();
    end
    initial begin
        logic a;
        rnd = 32'h4334;
        pins = rnd[2:0];
        wp_n = 1'b1;
        repeat (2) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (6) @(negedge core_clk);
        chk_val(wiper, 10'h000);
        for (int k = 0; k < 3; k++) begin
            rnd = lfsr(rnd);
            wiper_m = rnd[9:0];
            wr(ins(spcs_pkg::OP_WR_WIPER, 0), wiper_m);
            chk_val(wiper, 10'(wiper_m));
            chk_val(10'($countones(tap)), 10'h001);
            chk_ack(tap[wiper_m], 1'b1);
            chk_ack(busy, 1'b0);
            rd(ins(spcs_pkg::OP_RD_WIPER, 0), wiper_m);
        end
        for (int s = 0; s < 4; s++) begin
            rnd = lfsr(rnd);
            stored_m[s] = rnd[9:0];
            wr(ins(spcs_pkg::OP_WR_STORED, s), stored_m[s]);
            poll();
            rd(ins(spcs_pkg::OP_RD_STORED, s), stored_m[s]);
            chk_val(wiper, 10'(wiper_m));
        end
        for (int s = 3; s >= 0; s--) begin
            cmd(1'b1, ins(spcs_pkg::OP_COPY_TO_WIPER, s), 1'b1);
            mst.stop();
            wiper_m = stored_m[s];
            chk_val(wiper, 10'(wiper_m));
            chk_ack(busy, 1'b0);
        end
        wr(ins(spcs_pkg::OP_WR_WIPER, 0), 10'h3FF);
        wiper_m = 10'h3FF;
        cmd(1'b0, ins(spcs_pkg::OP_COPY_TO_STORED, 2), 1'b1);
        mst.stop();
        poll();
        stored_m[2] = wiper_m;
        rd(ins(spcs_pkg::OP_RD_STORED, 2), stored_m[2]);
        wp_n = 1'b0;
        wr(ins(spcs_pkg::OP_WR_STORED, 1), 10'h155);
        chk_ack(busy, 1'b0);
        cmd(1'b0, ins(spcs_pkg::OP_COPY_TO_STORED, 1), 1'b1);
        mst.stop();
        chk_ack(busy, 1'b0);
        wp_n = 1'b1;
        rd(ins(spcs_pkg::OP_RD_STORED, 1), stored_m[1]);
        for (int k = 0; k < 2; k++) begin
            mst.start();
            mst.wbyte({dev ^ 4'(k == 0), pins ^ 3'(k), 1'b0}, a);
            chk_ack(a, 1'b0);
            mst.stop();
        end
        cmd(1'b0, 8'h80, 1'b0);
        mst.stop();
        cmd(1'b1, 8'hE0, 1'b0);
        mst.stop();
        cmd(1'b0, 8'hB0, 1'b0);
        mst.stop();
        cmd(1'b0, 8'hA1, 1'b0);
        mst.stop();
        chk_val(wiper, 10'(wiper_m));
        @(negedge core_clk);
        arst_n = 1'b0;
        repeat (2) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (6) @(negedge core_clk);
        chk_val(wiper, 10'h000);
        end_sim();
    end
endmodule
